// ==== verilog/fsl_pkg.sv ====
// Constants shared by the fault status latch bank
package fsl_pkg;

  // ---------------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] VOLT_HI_FAULTS_ADDR = 8'h42;
  localparam logic [7:0] FUSE_VCORE_DIODE_ADDR = 8'h43;

  // ---------------------------------------------------------------------
  // Reset values and implemented bits
  // ---------------------------------------------------------------------
  localparam logic [7:0] VOLT_HI_RESET = 8'h00;
  localparam logic [7:0] FUSE_VCORE_RESET = 8'h00;
  localparam logic [7:0] VOLT_HI_IMPL = 8'hFF;
  localparam logic [7:0] FUSE_VCORE_IMPL = 8'hFC;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ---------------------------------------------------------------------
  // Sleep masking classes per bit
  // ---------------------------------------------------------------------
  // Plain: blocked in either sleep state; qualified: blocked only when
  // the qualifier input is also high
  localparam logic [7:0] VOLT_HI_PLAIN_MASK = 8'h47;
  localparam logic [7:0] VOLT_HI_QUAL_MASK = 8'h38;
  localparam logic [7:0] FUSE_VCORE_PLAIN_MASK = 8'h3C;
  localparam logic [7:0] FUSE_VCORE_QUAL_MASK = 8'hC0;

  // ---------------------------------------------------------------------
  // Field positions of the second register, and of channel 16 in the first
  // ---------------------------------------------------------------------
  localparam int FUSE1_BIT = 2;
  localparam int FUSE2_BIT = 3;
  localparam int CPU1_VCORE_BIT = 4;
  localparam int CPU2_VCORE_BIT = 5;
  localparam int DIODE1_BIT = 6;
  localparam int DIODE2_BIT = 7;
  localparam int CHAN16_BIT = 7;

endpackage : fsl_pkg

// ==== verilog/fsl_w1c_reg.sv ====
// Sticky write-one-to-clear status register
`timescale 1ns/1ps

module fsl_w1c_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] IMPL_MASK = '1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Hardware set and software clear, per bit
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  // Latched flags
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // Set beats clear so an event in the clearing cycle is never lost
  always_comb begin
    flags_next = ((flags_reg & ~clr_in) | set_in) & IMPL_MASK;
  end

  // Registered flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_reg <= RESET_VAL;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign q = flags_reg;

endmodule : fsl_w1c_reg

// ==== verilog/fsl_fault_status_latches.sv ====
// Two sticky fault status registers with sleep-state masking
`timescale 1ns/1ps

module fsl_fault_status_latches (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [fsl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [fsl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [fsl_pkg::DATA_W-1:0] reg_rdata,
  // Sleep state and masking qualifier
  input wire logic sleep_s3,
  input wire logic sleep_s45,
  input wire logic sleep_qualifier,
  // Voltage channels 9 to 16 outside their limit window
  input wire logic [7:0] chan_window_fault,
  // Termination fuse inputs
  input wire logic termination_fuse_in1,
  input wire logic termination_fuse_in2,
  // Core voltage against requested voltage mismatch
  input wire logic cpu1_vcore_mismatch,
  input wire logic cpu2_vcore_mismatch,
  // Remote diode open or short detect
  input wire logic diode1_fault,
  input wire logic diode2_fault,
  // Latched register contents
  output logic [fsl_pkg::DATA_W-1:0] volt_hi_faults,
  output logic [fsl_pkg::DATA_W-1:0] fuse_vcore_faults
);
  import fsl_pkg::*;

  // ---------------------------------------------------------------------
  // Sleep masking
  // ---------------------------------------------------------------------
  logic asleep;
  logic qual_sleep;
  logic [7:0] volt_block;
  logic [7:0] fuse_block;

  // Either sleep state counts; the qualifier is an external condition
  always_comb begin
    asleep = sleep_s3 | sleep_s45;
    qual_sleep = asleep & sleep_qualifier;
  end

  // ---------------------------------------------------------------------
  // Event sources per bit
  // ---------------------------------------------------------------------
  logic [7:0] volt_raw;
  logic [7:0] fuse_raw;
  logic [7:0] volt_set;
  logic [7:0] fuse_set;

  // Gather the second register's sources at their bit positions
  always_comb begin
    volt_raw = chan_window_fault;
    fuse_raw = 8'h00;
    fuse_raw[FUSE1_BIT] = termination_fuse_in1;
    fuse_raw[FUSE2_BIT] = termination_fuse_in2;
    fuse_raw[CPU1_VCORE_BIT] = cpu1_vcore_mismatch;
    fuse_raw[CPU2_VCORE_BIT] = cpu2_vcore_mismatch;
    fuse_raw[DIODE1_BIT] = diode1_fault;
    fuse_raw[DIODE2_BIT] = diode2_fault;
  end

  // Per-bit block from the masking class of that bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mask
      // Bit 7 of the first register is in neither class
      assign volt_block[gi] = (VOLT_HI_PLAIN_MASK[gi] & asleep) |
                              (VOLT_HI_QUAL_MASK[gi] & qual_sleep);
      assign fuse_block[gi] = (FUSE_VCORE_PLAIN_MASK[gi] & asleep) |
                              (FUSE_VCORE_QUAL_MASK[gi] & qual_sleep);
      assign volt_set[gi] = volt_raw[gi] &
                            ~volt_block[gi];
      assign fuse_set[gi] = fuse_raw[gi] &
                            ~fuse_block[gi];
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------
  logic volt_wr_hit;
  logic fuse_wr_hit;
  logic [7:0] volt_clr;
  logic [7:0] fuse_clr;

  // A write of one clears; writes elsewhere are ignored
  always_comb begin
    volt_wr_hit = 1'b0;
    fuse_wr_hit = 1'b0;
    if (reg_wr && reg_addr == VOLT_HI_FAULTS_ADDR) begin
      volt_wr_hit = 1'b1;
    end else if (reg_wr && reg_addr == FUSE_VCORE_DIODE_ADDR) begin
      fuse_wr_hit = 1'b1;
    end
    volt_clr = volt_wr_hit ? reg_wdata : 8'h00;
    fuse_clr = fuse_wr_hit ? (reg_wdata & FUSE_VCORE_IMPL) : 8'h00;
  end

  // ---------------------------------------------------------------------
  // Sticky registers
  // ---------------------------------------------------------------------
  // Reserved bits are pruned by the implemented mask
  fsl_w1c_reg #(
    .WIDTH(DATA_W),
    .IMPL_MASK(VOLT_HI_IMPL),
    .RESET_VAL(VOLT_HI_RESET)
  ) u_volt_hi (
    .mclk(mclk),
    .rst(rst),
    .set_in(volt_set),
    .clr_in(volt_clr),
    .q(volt_hi_faults)
  );

  fsl_w1c_reg #(
    .WIDTH(DATA_W),
    .IMPL_MASK(FUSE_VCORE_IMPL),
    .RESET_VAL(FUSE_VCORE_RESET)
  ) u_fuse_vcore (
    .mclk(mclk),
    .rst(rst),
    .set_in(fuse_set),
    .clr_in(fuse_clr),
    .q(fuse_vcore_faults)
  );

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Registered read data, one cycle after the strobe; holds otherwise.
  // Unmapped offsets return zero rather than stale data.
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (reg_addr == VOLT_HI_FAULTS_ADDR) begin
        rdata_next = volt_hi_faults;
      end else if (reg_addr == FUSE_VCORE_DIODE_ADDR) begin
        rdata_next = fuse_vcore_faults & FUSE_VCORE_IMPL;
      end else begin
        rdata_next = READ_ZERO;
      end
    end
  end

  // Read data register
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Awake channel 9 fault lands next cycle
  chan_set_a: assert property (
    (!asleep && chan_window_fault[0]) |=> volt_hi_faults[0])
    else $error("channel 9 fault not latched");

  // Channel 16 latches even while asleep
  chan16_nomask_a: assert property (
    (asleep && chan_window_fault[CHAN16_BIT])
      |=> volt_hi_faults[CHAN16_BIT])
    else $error("channel 16 fault suppressed by sleep");

  // Qualified sleep keeps a clear channel 13 flag clear
  qual_mask_a: assert property (
    (qual_sleep && !volt_hi_faults[4]) |=> !volt_hi_faults[4])
    else $error("channel 13 set under qualified sleep");

  // Unqualified sleep still lets channel 12 through
  qual_pass_a: assert property (
    (asleep && !sleep_qualifier && chan_window_fault[3])
      |=> volt_hi_faults[3])
    else $error("channel 12 masked without qualifier");

  // Sleep keeps channel 15 from setting
  plain_mask_a: assert property (
    (asleep && !volt_hi_faults[6]) |=> !volt_hi_faults[6])
    else $error("channel 15 set during sleep");

  // Fuse 1 awake sets bit 2
  fuse1_set_a: assert property (
    (!asleep && termination_fuse_in1) |=> fuse_vcore_faults[FUSE1_BIT])
    else $error("fuse 1 fault not latched");

  // Fuse 2 is blocked while asleep
  fuse2_mask_a: assert property (
    (asleep && !fuse_vcore_faults[FUSE2_BIT])
      |=> !fuse_vcore_faults[FUSE2_BIT])
    else $error("fuse 2 set during sleep");

  // Diode faults latch unless qualified sleep
  diode_set_a: assert property (
    (!qual_sleep && diode1_fault && diode2_fault)
      |=> fuse_vcore_faults[DIODE2_BIT:DIODE1_BIT] == 2'b11)
    else $error("diode fault not latched");

  // Both core voltage mismatches land together
  vcore_set_a: assert property (
    (!asleep && cpu1_vcore_mismatch && cpu2_vcore_mismatch)
      |=> fuse_vcore_faults[CPU2_VCORE_BIT:CPU1_VCORE_BIT] == 2'b11)
    else $error("core voltage mismatch not latched");

  // A flag holds for three cycles without a clearing write
  sticky_hold_a: assert property (
    (volt_hi_faults[1] && !volt_wr_hit) ##1 !volt_wr_hit[*2]
      |-> volt_hi_faults[1])
    else $error("sticky flag dropped without clear");

  // Write one clears when no new event is pending
  w1c_clear_a: assert property (
    (volt_wr_hit && reg_wdata[1] && !volt_set[1]) |=> !volt_hi_faults[1])
    else $error("write one did not clear flag");

  // Reserved bits never read back
  resv_zero_a: assert property (
    reg_rd && reg_addr == FUSE_VCORE_DIODE_ADDR |=> reg_rdata[1:0] == 2'b00)
    else $error("reserved bits read nonzero");

endmodule : fsl_fault_status_latches

// ==== verification/fsl_fault_status_latches_tb.sv ====
// Self-checking bench for the fault status latch bank
`timescale 1ns/1ps

`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end

module fsl_fault_status_latches_tb;
  import fsl_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep_s3 = 1'b0;
  logic sleep_s45 = 1'b0;
  logic sleep_qualifier = 1'b0;
  logic [7:0] chan_window_fault = 8'h00;
  logic [5:0] src = 6'h00;
  logic [7:0] volt_hi_faults;
  logic [7:0] fuse_vcore_faults;
  int fails = 0;
  int tests_run = 0;

  fsl_fault_status_latches i_fsl_fault_status_latches (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_s3(sleep_s3), .sleep_s45(sleep_s45),
    .sleep_qualifier(sleep_qualifier),
    .chan_window_fault(chan_window_fault),
    .termination_fuse_in1(src[0]), .termination_fuse_in2(src[1]),
    .cpu1_vcore_mismatch(src[2]), .cpu2_vcore_mismatch(src[3]),
    .diode1_fault(src[4]), .diode2_fault(src[5]),
    .volt_hi_faults(volt_hi_faults),
    .fuse_vcore_faults(fuse_vcore_faults)
  );

  // Clock, 5 ns period
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // Bus and stimulus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is due on the edge that takes the strobe, one cycle after the strobe is driven
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask : rd

  // One-cycle pulse on the event sources
  task automatic pulse(input logic [7:0] ch, input logic [5:0] o);
    @(posedge mclk);
    chan_window_fault <= ch;
    src <= o;
    @(posedge mclk);
    chan_window_fault <= 8'h00;
    src <= 6'h00;
    @(posedge mclk);
  endtask : pulse

  // Checks both flag outputs and both registers over the bus
  task automatic chk2(input logic [7:0] e42, input logic [7:0] e43);
    #1;
    `CHK(volt_hi_faults, e42)
    `CHK(fuse_vcore_faults, e43)
    rd(VOLT_HI_FAULTS_ADDR, e42);
    rd(FUSE_VCORE_DIODE_ADDR, e43);
  endtask : chk2

  task automatic clr_all();
    wr(VOLT_HI_FAULTS_ADDR, 8'hFF);
    wr(FUSE_VCORE_DIODE_ADDR, 8'hFF);
    chk2(8'h00, 8'h00);
  endtask : clr_all

  task automatic summarize();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    chk2(8'h00, 8'h00);
    // Each voltage channel alone, then a write-one clear
    for (int n = 0; n < 8; n++) begin
      pulse(8'h01 << n, 6'h00);
      chk2(8'h01 << n, 8'h00);
      clr_all();
    end
    // Each source of the second register; bits 1:0 never set
    for (int k = 0; k < 6; k++) begin
      pulse(8'h00, 6'h01 << k);
      chk2(8'h00, 8'h04 << k);
      clr_all();
    end
    // Both sleep states, with and without the qualifier
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      sleep_s3 <= ~i[0];
      sleep_s45 <= i[0];
      sleep_qualifier <= i[1];
      pulse(8'hFF, 6'h3F);
      chk2(i[1] ? 8'h80 : 8'hB8, i[1] ? 8'h00 : 8'hC0);
      chk2(i[1] ? 8'h80 : 8'hB8, i[1] ? 8'h00 : 8'hC0);
      clr_all();
    end
    @(posedge mclk);
    sleep_s3 <= 1'b0;
    sleep_s45 <= 1'b0;
    // Awake, every source of both registers lands together
    pulse(8'hFF, 6'h3F);
    chk2(8'hFF, 8'hFC);
    clr_all();
    // Event only in the clearing cycle still sets; partial clear keeps
    // the other bits
    fork
      wr(VOLT_HI_FAULTS_ADDR, 8'h01);
      begin
        @(posedge mclk);
        chan_window_fault <= 8'h81;
        @(posedge mclk);
        chan_window_fault <= 8'h00;
      end
    join
    chk2(8'h81, 8'h00);
    wr(VOLT_HI_FAULTS_ADDR, 8'h01);
    chk2(8'h80, 8'h00);
    // Unmapped place reads zero and a write there clears nothing;
    // a nonzero read first so stale read data would show
    rd(VOLT_HI_FAULTS_ADDR, 8'h80);
    rd(8'h44, 8'h00);
    wr(8'h44, 8'hFF);
    chk2(8'h80, 8'h00);
    // Reset mid-run drops a held flag and nonzero read data
    rd(VOLT_HI_FAULTS_ADDR, 8'h80);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1;
    `CHK(reg_rdata, 8'h00)
    chk2(8'h00, 8'h00);
    summarize();
  end

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    summarize();
  end

endmodule : fsl_fault_status_latches_tb
